// >>> hdl/otseq_pkg.sv
package otseq_pkg;
  // channel count and field widths
  localparam int NCH       = 3;
  localparam int SET_W     = 16;   // voltage / current setting code width
  localparam int DLY_W     = 10;   // delay in 0.1 s units, up to 99.9 s
  localparam int PCT_W     = 10;   // tracking percentage, whole percent
  localparam int PCT_FULL  = 100;  // percentage meaning unity gain
  // timing: one delay unit is 100 ms
  localparam int CLK_MHZ   = 250;
  localparam int DLY_UNIT_MS = 100;
  localparam int TICK_CYC  = CLK_MHZ * 1000 * DLY_UNIT_MS;
  localparam logic [DLY_W-1:0] DLY_ZERO = '0;
  // trigger source codes
  localparam logic SRC_BUS = 1'b0;
  localparam logic SRC_IMM = 1'b1;
  // sequencer states
  typedef enum logic [1:0] {OTSEQ_IDLE, OTSEQ_INIT, OTSEQ_WTG, OTSEQ_ACT} otseq_state_e;
endpackage : otseq_pkg

// >>> hdl/otseq_chan_delay.sv
`timescale 1ns/10ps
// one channel's output delay timer
module otseq_chan_delay
  import otseq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,      // one pulse per delay unit
  input  wire logic             start,     // begin counting toward target state
  input  wire logic             target,    // state to apply when count ends
  input  wire logic [DLY_W-1:0] wait_val,  // wait in units
  input  wire logic             cancel,    // stop counting, no change
  output logic                  busy,      // counting in progress
  output logic                  fire       // pulse: apply target now
);
  logic [DLY_W-1:0] cnt_q;   // units remaining
  logic             run_q;   // counting

  // countdown; zero wait fires in the start cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (cancel) begin
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= wait_val;
      run_q <= (wait_val != DLY_ZERO);
    end else if (run_q && tick) begin
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == {{(DLY_W-1){1'b0}}, 1'b1}) run_q <= 1'b0;
    end
  end

  assign busy = run_q;
  assign fire = !cancel && ((start && wait_val == DLY_ZERO) ||
                (run_q && tick && cnt_q == {{(DLY_W-1){1'b0}}, 1'b1}));
  wire unused_target = target;
endmodule : otseq_chan_delay

// >>> hdl/otseq_top.sv
`timescale 1ns/10ps
module otseq_top
  import otseq_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 ABORT_CMD,        // abort command pulse
  input  wire logic                 DEV_RESET_CMD,    // device reset pulse
  input  wire logic                 RECALL_CMD,       // memory recall pulse
  input  wire logic                 DEV_CLEAR,        // interface device clear pulse
  input  wire logic                 SERIAL_BREAK,     // serial break pulse
  input  wire logic                 INIT_SEQ1,        // initiate transient
  input  wire logic                 INIT_SEQ2,        // initiate output
  input  wire logic                 TRIG_SEQ1,        // transient-only trigger
  input  wire logic                 TRIG_SEQ2,        // output-only trigger
  input  wire logic                 TRIG_COMMON,      // common trigger
  input  wire logic                 TRIG_GROUP,       // group execute trigger
  input  wire logic                 SRC_SEQ1,         // 1 = immediate, 0 = bus
  input  wire logic                 SRC_SEQ2,         // 1 = immediate, 0 = bus
  input  wire logic [1:0]           CHANNEL_SELECT,   // 0..2
  input  wire logic                 SET_VOLT_WR,      // write base voltage to sel ch
  input  wire logic                 SET_CURR_WR,      // write current to sel ch
  input  wire logic                 TRIG_VOLT_WR,     // write reserved voltage
  input  wire logic                 TRIG_CURR_WR,     // write reserved current
  input  wire logic [SET_W-1:0]     SET_DATA,         // data for the writes above
  input  wire logic                 ON_WAIT_WR,       // write turn_on_wait_time
  input  wire logic                 OFF_WAIT_WR,      // write turn_off_wait_time
  input  wire logic [DLY_W-1:0]     WAIT_DATA,        // wait in 0.1 s units
  input  wire logic                 DELAY_FEATURE_ENABLE,
  input  wire logic                 OUTPUT_CMD,       // direct global output command
  input  wire logic                 OUTPUT_CMD_ON,    // state for the command
  input  wire logic                 TRIG_OUT_STATE,   // state reserved for seq 2
  input  wire logic [NCH-1:0]       TRACK_FLAGS,      // tracking participation flags
  input  wire logic                 PROPORTIONAL_TRACKING,
  input  wire logic                 ABSOLUTE_TRACKING,
  input  wire logic [PCT_W-1:0]     TRACKING_PERCENTAGE,
  input  wire logic                 PCT_WR,           // apply tracking percentage
  output logic [1:0]                SEQ1_STATE,
  output logic [1:0]                SEQ2_STATE,
  output logic [NCH-1:0]            OUTPUT_ON,
  output logic [NCH*SET_W-1:0]      VOLT_OUT,
  output logic [NCH*SET_W-1:0]      CURR_OUT
);
  otseq_state_e       s1_q, s2_q;             // independent sequencer states
  logic [NCH-1:0]     trk_q;                  // participation flags
  logic [SET_W-1:0]   volt_q [NCH];           // active voltage
  logic [SET_W-1:0]   curr_q [NCH];           // active current
  logic [SET_W-1:0]   tvolt_q [NCH];          // reserved triggered voltage
  logic [SET_W-1:0]   tcurr_q [NCH];          // reserved triggered current
  logic [DLY_W-1:0]   on_w_q [NCH];           // per-channel on wait
  logic [DLY_W-1:0]   off_w_q [NCH];          // per-channel off wait
  logic [NCH-1:0]     out_q;                  // output states
  logic [NCH-1:0]     saved_q;                // state before delay action
  logic [31:0]        tick_cnt_q;             // delay unit divider
  logic               tick;
  logic [NCH-1:0]     busy, fire;
  logic               dly_go, dly_target;
  logic [SET_W-1:0]   ref_volt;               // reference channel voltage
  logic               trk_ref;                // reference channel takes part
  logic               dly_target_q;           // target held for the action's length

  // any event that forces all sequencers idle
  wire force_idle = ABORT_CMD | DEV_RESET_CMD | RECALL_CMD | DEV_CLEAR | SERIAL_BREAK;
  wire trig1 = TRIG_SEQ1 | TRIG_COMMON | TRIG_GROUP;
  wire trig2 = TRIG_SEQ2 | TRIG_COMMON | TRIG_GROUP;
  wire act1  = (s1_q == OTSEQ_ACT);
  wire s2_done = (s2_q == OTSEQ_ACT) && (busy == '0) && !dly_go;
  // direct command with the delay feature on and no action running: timers time it
  wire cmd_delayed = OUTPUT_CMD && DELAY_FEATURE_ENABLE && !force_idle &&
                     (s2_q != OTSEQ_ACT) && (busy == '0);
  // a delay action is running, either the sequencer's or a timed command's
  wire dly_active = (s2_q == OTSEQ_ACT) || (busy != '0);
  // a command during a running action aborts it and applies at once
  wire cancel_dly = force_idle | (OUTPUT_CMD & !cmd_delayed);

  // transient sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) s1_q <= OTSEQ_IDLE;
    else if (force_idle) s1_q <= OTSEQ_IDLE;
    else case (s1_q)
      OTSEQ_IDLE: if (INIT_SEQ1) s1_q <= OTSEQ_INIT;
      OTSEQ_INIT: s1_q <= (SRC_SEQ1 == SRC_IMM) ? OTSEQ_ACT : OTSEQ_WTG;
      OTSEQ_WTG:  if (trig1) s1_q <= OTSEQ_ACT;
      OTSEQ_ACT:  s1_q <= OTSEQ_IDLE;
      default:    s1_q <= OTSEQ_IDLE;
    endcase
  end

  // output sequencer, separate state and source
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) s2_q <= OTSEQ_IDLE;
    else if (force_idle || OUTPUT_CMD) s2_q <= OTSEQ_IDLE;
    else case (s2_q)
      OTSEQ_IDLE: if (INIT_SEQ2) s2_q <= OTSEQ_INIT;
      OTSEQ_INIT: s2_q <= (SRC_SEQ2 == SRC_IMM) ? OTSEQ_ACT : OTSEQ_WTG;
      OTSEQ_WTG:  if (trig2) s2_q <= OTSEQ_ACT;
      OTSEQ_ACT:  if (s2_done) s2_q <= OTSEQ_IDLE;
      default:    s2_q <= OTSEQ_IDLE;
    endcase
  end

  // delay-unit tick divider
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) tick_cnt_q <= '0;
    else if (tick || dly_go) tick_cnt_q <= '0;        // a new action waits full units
    else tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

  // start of a delay action: sequencer entering action, or delayed direct command
  wire seq2_start = ((s2_q == OTSEQ_INIT) && (SRC_SEQ2 == SRC_IMM) ||
                     (s2_q == OTSEQ_WTG) && trig2) && !force_idle && !OUTPUT_CMD;
  assign dly_go     = seq2_start || cmd_delayed;
  assign dly_target = cmd_delayed ? OUTPUT_CMD_ON : TRIG_OUT_STATE;

  // per-channel timers and settings
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire sel = (CHANNEL_SELECT == 2'(g));
      otseq_chan_delay u_dly (
        .clk      (CLK),
        .rst_n    (RST_N),
        .tick     (tick),
        .start    (dly_go && (out_q[g] != dly_target)),
        .target   (dly_target),
        .wait_val (dly_target ? on_w_q[g] : off_w_q[g]),
        .cancel   (cancel_dly),
        .busy     (busy[g]),
        .fire     (fire[g])
      );

      // per-channel wait storage
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          on_w_q[g]  <= '0;
          off_w_q[g] <= '0;
        end else begin
          if (ON_WAIT_WR && sel)  on_w_q[g]  <= WAIT_DATA;
          if (OFF_WAIT_WR && sel) off_w_q[g] <= WAIT_DATA;
        end
      end

      // output state: reset forces off, abort restores, command applies
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) out_q[g] <= 1'b0;
        else if (DEV_RESET_CMD) out_q[g] <= 1'b0;
        else if (OUTPUT_CMD && !cmd_delayed) out_q[g] <= OUTPUT_CMD_ON;
        else if (force_idle && dly_active) out_q[g] <= saved_q[g];
        else if (fire[g]) out_q[g] <= dly_go ? dly_target : dly_target_q;
      end

      // reserved and active settings, tracking
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          volt_q[g]  <= '0;
          curr_q[g]  <= '0;
          tvolt_q[g] <= '0;
          tcurr_q[g] <= '0;
        end else begin
          if (TRIG_VOLT_WR && sel) tvolt_q[g] <= SET_DATA;
          if (TRIG_CURR_WR && sel) tcurr_q[g] <= SET_DATA;
          if (SET_CURR_WR && sel) curr_q[g] <= SET_DATA;
          if (act1) begin
            volt_q[g] <= tvolt_q[g];
            curr_q[g] <= tcurr_q[g];
          end else if (SET_VOLT_WR && sel) volt_q[g] <= SET_DATA;
          else if (SET_VOLT_WR && ABSOLUTE_TRACKING && trk_q[g] && trk_ref)
            volt_q[g] <= volt_q[g] + (SET_DATA - ref_volt);
          else if (PCT_WR && PROPORTIONAL_TRACKING && trk_q[g])
            volt_q[g] <= SET_W'((32'(volt_q[g]) * 32'(TRACKING_PERCENTAGE))
                                / PCT_FULL);
        end
      end
      assign VOLT_OUT[g*SET_W +: SET_W] = volt_q[g];
      assign CURR_OUT[g*SET_W +: SET_W] = curr_q[g];
    end
  endgenerate

  // reference channel data for absolute tracking
  always_comb begin
    ref_volt = volt_q[0];
    trk_ref  = trk_q[0];
    for (int i = 0; i < NCH; i++) begin
      if (CHANNEL_SELECT == 2'(i)) begin
        ref_volt = volt_q[i];
        trk_ref  = trk_q[i];
      end
    end
  end

  // participation flags, saved output, held target
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      trk_q        <= '0;
      saved_q      <= '0;
      dly_target_q <= 1'b0;
    end else begin
      trk_q <= TRACK_FLAGS;
      if (dly_go) begin
        saved_q      <= out_q;
        dly_target_q <= dly_target;
      end
    end
  end

  assign OUTPUT_ON  = out_q;
  assign SEQ1_STATE = s1_q;
  assign SEQ2_STATE = s2_q;

  // checks
  // an output sequencer armed for the bus trigger that sees its own, common or group trigger
  sequence s_seq2_armed;
    s2_q == OTSEQ_WTG && trig2 && !force_idle && !OUTPUT_CMD;
  endsequence
  // the transient action lasts one cycle and then the sequencer rests
  sequence s_seq1_act_then_idle;
    act1 ##1 s1_q == OTSEQ_IDLE;
  endsequence

  // an idle transient sequencer stays idle without an initiate
  a_idle_ignores_trig: assert property (@(posedge CLK) disable iff (!RST_N)
    (s1_q == OTSEQ_IDLE && !INIT_SEQ1) |=> s1_q == OTSEQ_IDLE)
    else $error("transient left idle without initiate");
  // the same holds for the output sequencer
  a_idle2_ignores_trig: assert property (@(posedge CLK) disable iff (!RST_N)
    (s2_q == OTSEQ_IDLE && !INIT_SEQ2) |=> s2_q == OTSEQ_IDLE)
    else $error("output sequencer left idle without initiate");
  // every force-idle event idles both sequencers
  a_abort_forces_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    force_idle |=> (s1_q == OTSEQ_IDLE && s2_q == OTSEQ_IDLE))
    else $error("abort did not idle sequencers");
  // initiate moves an idle transient sequencer on
  a_init_from_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    (s1_q == OTSEQ_IDLE && INIT_SEQ1 && !force_idle) |=> s1_q == OTSEQ_INIT)
    else $error("initiate not taken");
  // immediate source: action next cycle, idle the cycle after
  a_imm_source_acts: assert property (@(posedge CLK) disable iff (!RST_N)
    (s1_q == OTSEQ_INIT && SRC_SEQ1 && !force_idle) |=> s_seq1_act_then_idle)
    else $error("immediate source did not act then idle");
  // immediate source on the output sequencer enters the action
  a_imm2_source_acts: assert property (@(posedge CLK) disable iff (!RST_N)
    (s2_q == OTSEQ_INIT && SRC_SEQ2 == SRC_IMM && !force_idle && !OUTPUT_CMD)
    |=> s2_q == OTSEQ_ACT)
    else $error("immediate source did not start output action");
  // bus source: the transient sequencer waits for a trigger
  a_bus1_source_waits: assert property (@(posedge CLK) disable iff (!RST_N)
    (s1_q == OTSEQ_INIT && SRC_SEQ1 == SRC_BUS && !force_idle) |=> s1_q == OTSEQ_WTG)
    else $error("bus source did not wait on transient");
  // bus source: the output sequencer waits for a trigger
  a_bus_source_waits: assert property (@(posedge CLK) disable iff (!RST_N)
    (s2_q == OTSEQ_INIT && !SRC_SEQ2 && !force_idle && !OUTPUT_CMD) |=> s2_q == OTSEQ_WTG)
    else $error("bus source did not wait");
  // a trigger while waiting starts the transient action
  a_trig_starts_act: assert property (@(posedge CLK) disable iff (!RST_N)
    (s1_q == OTSEQ_WTG && trig1 && !force_idle) |=> act1)
    else $error("trigger did not start action");
  // the transient action always ends in idle
  a_act_ends_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    act1 |=> s1_q == OTSEQ_IDLE)
    else $error("transient action did not end in idle");
  // the sequence 1 trigger leaves the output sequencer waiting
  a_seq_trig_isolated: assert property (@(posedge CLK) disable iff (!RST_N)
    (s2_q == OTSEQ_WTG && TRIG_SEQ1 && !trig2 && !force_idle && !OUTPUT_CMD)
    |=> s2_q == OTSEQ_WTG)
    else $error("sequence 1 trigger reached output sequencer");
  // common and group triggers start the output sequencer too
  a_group_trig_both: assert property (@(posedge CLK) disable iff (!RST_N)
    s_seq2_armed |=> s2_q == OTSEQ_ACT)
    else $error("fanned-out trigger did not start output sequencer");
  // the output-only trigger leaves the transient sequencer waiting
  a_seq1_keeps_own: assert property (@(posedge CLK) disable iff (!RST_N)
    (s1_q == OTSEQ_WTG && TRIG_SEQ2 && !trig1 && !force_idle) |=> s1_q == OTSEQ_WTG)
    else $error("output trigger moved the transient sequencer");
  // a zero on-wait switches channel 0 in the start cycle
  a_zero_wait_now: assert property (@(posedge CLK) disable iff (!RST_N)
    (seq2_start && TRIG_OUT_STATE && on_w_q[0] == DLY_ZERO) |=> OUTPUT_ON[0])
    else $error("zero wait did not switch at once");
  // an abort during a delay action puts back the saved outputs
  a_abort_restores: assert property (@(posedge CLK) disable iff (!RST_N)
    (force_idle && !DEV_RESET_CMD && !OUTPUT_CMD && dly_active)
    |=> OUTPUT_ON == $past(saved_q))
    else $error("abort did not restore outputs");
  // device reset always leaves the outputs off
  a_reset_output_off: assert property (@(posedge CLK) disable iff (!RST_N)
    DEV_RESET_CMD |=> OUTPUT_ON == '0)
    else $error("device reset left output on");
  // a direct command during a running delay applies at once
  a_direct_cmd_applies: assert property (@(posedge CLK) disable iff (!RST_N)
    (OUTPUT_CMD && !DEV_RESET_CMD && busy != '0)
    |=> OUTPUT_ON == {NCH{$past(OUTPUT_CMD_ON)}})
    else $error("direct command did not override delay");
endmodule : otseq_top

// >>> verif/ots_host.sv
`timescale 1ns/10ps
// host side: issues one-cycle command pulses, one bit per command
module ots_host (
  input  wire logic        clk,
  output logic      [18:0] pulse   // command pulse vector
);
  initial pulse = '0;
  // raise a single command for one cycle, launched off the falling edge
  task automatic send(input int b);
    @(negedge clk);
    pulse[b] = 1'b1;
    @(negedge clk);
    pulse = '0;
  endtask : send
endmodule : ots_host

// >>> verif/test_output_trigger_sequencer.sv
`timescale 1ns/10ps
module test_output_trigger_sequencer;
  import otseq_pkg::*;
  typedef struct {int k; logic [15:0] v;} ots_note_s;  // expected result note
  localparam int AB = 0, DR = 1, SB = 4, INI1 = 5, INI2 = 6, T1 = 7, T2 = 8, TC = 9, TG = 10;
  localparam int SV = 11, SC = 12, TV = 13, TI = 14, ONW = 15, OFW = 16, OC = 17, PW = 18;
  logic CLK = 1'b0, RST_N = 1'b0;
  logic [18:0] p;                       // command pulses from the host
  logic src1 = 0, src2 = 0, dfe = 0, oon = 0, tos = 0, prop = 0, absm = 0;
  logic [1:0] chsel = '0;
  logic [SET_W-1:0] sdat = '0;
  logic [DLY_W-1:0] wdat = '0;
  logic [NCH-1:0] flags = '0;
  logic [PCT_W-1:0] pct = '0;
  logic [1:0] s1, s2;
  logic [NCH-1:0] OUTPUT_ON;
  logic [NCH*SET_W-1:0] VOLT_OUT, CURR_OUT;
  logic [31:0] rnd = 32'h322EBF36;      // xorshift state
  logic [15:0] rv, rc;
  int fails = 0, checked = 0, cyc = 0;
  int fi[5] = '{0, 2, 3, 4, 1};         // force-idle commands, device reset last
  ots_note_s q[$];
  ots_note_s n;
  always #2 CLK = ~CLK;
  ots_host u_ots_host (.clk(CLK), .pulse(p));
  otseq_top u_otseq_top (.CLK(CLK), .RST_N(RST_N), .ABORT_CMD(p[0]), .DEV_RESET_CMD(p[1]),
    .RECALL_CMD(p[2]), .DEV_CLEAR(p[3]), .SERIAL_BREAK(p[4]), .INIT_SEQ1(p[5]),
    .INIT_SEQ2(p[6]), .TRIG_SEQ1(p[7]), .TRIG_SEQ2(p[8]), .TRIG_COMMON(p[9]),
    .TRIG_GROUP(p[10]), .SRC_SEQ1(src1), .SRC_SEQ2(src2), .CHANNEL_SELECT(chsel),
    .SET_VOLT_WR(p[11]), .SET_CURR_WR(p[12]), .TRIG_VOLT_WR(p[13]), .TRIG_CURR_WR(p[14]),
    .SET_DATA(sdat), .ON_WAIT_WR(p[15]), .OFF_WAIT_WR(p[16]), .WAIT_DATA(wdat),
    .DELAY_FEATURE_ENABLE(dfe), .OUTPUT_CMD(p[17]), .OUTPUT_CMD_ON(oon),
    .TRIG_OUT_STATE(tos), .TRACK_FLAGS(flags), .PROPORTIONAL_TRACKING(prop),
    .ABSOLUTE_TRACKING(absm), .TRACKING_PERCENTAGE(pct), .PCT_WR(p[18]),
    .SEQ1_STATE(s1), .SEQ2_STATE(s2), .OUTPUT_ON(OUTPUT_ON), .VOLT_OUT(VOLT_OUT),
    .CURR_OUT(CURR_OUT));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // note kinds: 0/1 sequencer states, 2 outputs, 3..5 voltage, 6..8 current
  task automatic note(input int k, input logic [15:0] v);
    q.push_back('{k, v});
  endtask : note
  task automatic cmp_st(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t state %0h exp %0h", $time, g, e);
    end
  endtask : cmp_st
  task automatic cmp_on(input logic [2:0] g, input logic [2:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t outputs %0h exp %0h", $time, g, e);
    end
  endtask : cmp_on
  task automatic cmp_set(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t setting %0h exp %0h", $time, g, e);
    end
  endtask : cmp_set
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // monitor: settle after the falling edge, then match every pending note
  always @(negedge CLK) begin
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      if (n.k == 0) cmp_st(s1, n.v[1:0]);
      else if (n.k == 1) cmp_st(s2, n.v[1:0]);
      else if (n.k == 2) cmp_on(OUTPUT_ON, n.v[2:0]);
      else if (n.k < 6) cmp_set(VOLT_OUT[(n.k-3)*SET_W+:SET_W], n.v);
      else cmp_set(CURR_OUT[(n.k-6)*SET_W+:SET_W], n.v);
    end
  end
  // hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    rnd = xs(rnd);
    rv = rnd[15:0];
    rc = rnd[31:16];
    repeat (12) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    note(0, 0); note(1, 0); note(2, 0); note(3, 0); note(6, 0);
    sdat = rv; u_ots_host.send(TV);
    sdat = rc; u_ots_host.send(TI);
    u_ots_host.send(TC); note(0, 0); note(3, 0);
    u_ots_host.send(TG); note(0, 0); note(1, 0); note(3, 0);
    u_ots_host.send(INI1); note(0, 1);
    @(negedge CLK); note(0, 2);
    u_ots_host.send(T2); note(0, 2);
    u_ots_host.send(T1); note(0, 3);
    @(negedge CLK); note(0, 0); note(3, rv); note(6, rc);
    sdat = ~rv; u_ots_host.send(TV);
    foreach (fi[j]) begin
      u_ots_host.send(INI1);
      u_ots_host.send(INI2);
      u_ots_host.send(fi[j]); note(0, 0); note(1, 0);
      if (fi[j] != DR) note(3, rv);
    end
    rnd = xs(rnd);
    sdat = rnd[15:0]; u_ots_host.send(TV);
    chsel = 2'h1;
    sdat = rc; u_ots_host.send(SC); note(7, rc);
    src1 = 1'b1; u_ots_host.send(INI1); note(0, 1);
    @(negedge CLK); note(0, 3);
    @(negedge CLK); note(0, 0); note(3, rnd[15:0]);
    note(7, 16'h0000);
    dfe = 1'b1;
    for (int i = 0; i < 2; i++) begin
      tos = (i == 0);
      u_ots_host.send(INI2); note(1, 1);
      @(negedge CLK); note(1, 2);
      u_ots_host.send(T1); note(1, 2); note(0, 0);
      u_ots_host.send(i == 0 ? TG : TC);
      for (int w = 0; w < 20 && s2 !== 2'h0; w++) @(negedge CLK);
      note(1, 0); note(2, i == 0 ? 7 : 0);
    end
    oon = 1'b1; u_ots_host.send(OC);
    for (int w = 0; w < 20 && OUTPUT_ON !== 3'h7; w++) @(negedge CLK);
    note(2, 7);
    oon = 1'b0; u_ots_host.send(OC);
    for (int w = 0; w < 20 && OUTPUT_ON !== 3'h0; w++) @(negedge CLK);
    note(2, 0);
    chsel = 2'h2; wdat = 10'h001; u_ots_host.send(ONW);
    src2 = 1'b1; tos = 1'b1; u_ots_host.send(INI2); note(1, 1);
    @(negedge CLK); note(1, 3);
    repeat (20) @(negedge CLK);
    note(1, 3); note(2, 3);
    u_ots_host.send(AB);
    for (int w = 0; w < 20 && OUTPUT_ON !== 3'h0; w++) @(negedge CLK);
    note(1, 0); note(2, 0);
    wdat = '0; u_ots_host.send(ONW);
    wdat = 10'h001; u_ots_host.send(OFW);
    oon = 1'b1; u_ots_host.send(OC); note(2, 7);
    oon = 1'b0; u_ots_host.send(OC); note(2, 4);
    repeat (4) @(negedge CLK); note(2, 4);
    u_ots_host.send(SB); note(1, 0); note(2, 7);
    u_ots_host.send(OC); note(2, 4);
    oon = 1'b1; u_ots_host.send(OC); note(2, 7);
    u_ots_host.send(DR); note(2, 0);
    prop = 1'b1; flags = 3'b011;
    chsel = 2'h0; sdat = 16'h01F4; u_ots_host.send(SV);
    chsel = 2'h1; sdat = 16'h03E8; u_ots_host.send(SV);
    chsel = 2'h2; sdat = 16'h0064; u_ots_host.send(SV);
    chsel = 2'h0; pct = 10'h078; u_ots_host.send(PW);
    for (int w = 0; w < 20 && VOLT_OUT[15:0] !== 16'h0258; w++) @(negedge CLK);
    note(3, 16'h0258); note(4, 16'h04B0); note(5, 16'h0064);
    prop = 1'b0; absm = 1'b1; flags = 3'b101;
    sdat = 16'h02BC; u_ots_host.send(SV);
    for (int w = 0; w < 20 && VOLT_OUT[47:32] !== 16'h00C8; w++) @(negedge CLK);
    note(3, 16'h02BC); note(4, 16'h04B0); note(5, 16'h00C8);
    repeat (2) @(negedge CLK);
    close_out();
  end
endmodule : test_output_trigger_sequencer
